// [inc/pwm_job_map.svh]
/*
  Constant map of the job-driven pulse output controller: job codes,
  result codes, value ranges, time bases and duty scaling.
  Assumes one 100 MHz system clock; included by bare name.
*/
// Overview of operation
// - job 04h loads minimum pulse duration
// - done flag low while a job runs
// - failure sets error flag, nonzero result code
// - gate and strobe rising start PWM output
// - duty setting accepted anytime during output
// - new values apply at next period start
// - gate low stops output at once
// - read jobs return value in readback field
// - jobs 08h/01h load first train count/period
// - jobs 09h/0Ah load second train count/period
// - start runs first train, then second
// - train status high until count done or stopped
// - second job appendable while one train runs
// - job 0Ch appends, else result 0461h
// - at most two train jobs back to back
// - period and on-delay range errors
// - minimum pulse range errors 0431h/0432h
// - pulse count range errors 0441h/0442h
// - unknown job 04FFh, bad time base 0451h
// - channel errors 8001h and 8009h
// - no process interrupt is raised
`ifndef PWM_JOB_MAP_SVH
`define PWM_JOB_MAP_SVH

`define JOB_PERIOD    8'h01
`define JOB_ONDELAY   8'h02
`define JOB_MINPULSE  8'h04
`define JOB_COUNT1    8'h08
`define JOB_COUNT2    8'h09
`define JOB_PERIOD2   8'h0A
`define JOB_ATTACH    8'h0C
`define JOB_RD_PERIOD 8'h81
`define JOB_RD_ONDLY  8'h82
`define JOB_RD_MINP   8'h84
`define JOB_RD_REMAIN 8'h88

`define ST_OK         16'h0000
`define ST_PER_SMALL  16'h0411
`define ST_PER_BIG    16'h0412
`define ST_DLY_SMALL  16'h0421
`define ST_DLY_BIG    16'h0422
`define ST_MINP_SMALL 16'h0431
`define ST_MINP_BIG   16'h0432
`define ST_CNT_SMALL  16'h0441
`define ST_CNT_BIG    16'h0442
`define ST_TB_BAD     16'h0451
`define ST_NO_ATTACH  16'h0461
`define ST_BAD_JOB    16'h04FF
`define ST_PARAM_ERR  16'h8001
`define ST_CHAN_BAD   16'h8009

`define PER_MIN       32'h0000_0002
`define PER_MAX       32'h0000_EA60
`define DLY_MIN       32'h0000_0001
`define DLY_MAX       32'h0000_EA60
`define MINP_MIN      32'h0000_0001
`define MINP_MAX      32'h0000_EA60
`define CNT_MIN       32'h0000_0001
`define CNT_MAX       32'h0000_FFFF

`define CHAN_LAST     4'h3
`define TB_FINE       2'h0
`define TB_COARSE     2'h1
`define CLK_NS        1000'd10
`define TB_FINE_NS    1000'd1000
`define TB_COARSE_NS  1000'd10000
`define DUTY_FULL     16'h4000
`define DUTY_SHIFT    14

`endif

// [inc/pwm_job_pkg.sv]
/*
  Types of the pulse output controller.
  Assumes the map header is compiled alongside.
*/
package pwm_job_pkg;
  typedef enum logic [0:0] {
    JOB_IDLE = 1'b0,
    JOB_BUSY = 1'b1
  } job_state_e;
endpackage

// [verilog/edge_rise.sv]
/*
  Rising edge finder for a group of synchronous levels.
  Assumes inputs already synchronous to the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module edge_rise #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] level_in,
  output var  logic [W-1:0] rise_out
);
  logic [W-1:0] prev_r;

  // previous-cycle copy; a held level looks like a new edge only in the first cycle after reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_r <= '0;
    end else begin
      prev_r <= level_in;
    end
  end

  assign rise_out = level_in & ~prev_r;
endmodule // edge_rise
`default_nettype wire

// [verilog/tick_divider.sv]
/*
  Time base divider: one-cycle tick every div_in cycles while run_in.
  Assumes div_in is held stable while running.
*/
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int W = 10
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rstn_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] div_in,
  output var  logic         tick_out
);
  logic [W-1:0] cnt_r;

  // restarts on every stop so a fresh period gets a full first unit
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= '0;
    end else if (!run_in || cnt_r == div_in - W'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign tick_out = run_in && (cnt_r == div_in - W'(1));
endmodule // tick_divider
`default_nettype wire

// [verilog/pulse_output_function_block.sv]
/*
  Job-driven controller of one PWM / pulse-train output channel.
  Assumes a host that pulses the request strobe with stable inputs
  and a single 100 MHz clock; all inputs are synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pwm_job_map.svh"
module pulse_output_function_block
  import pwm_job_pkg::*;
#(
  parameter int NUM_CHANNELS = 4
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        job_req_in,
  input  wire logic        software_gate_in,
  input  wire logic [7:0]  command_code_in,
  input  wire logic [31:0] command_operand_in,
  input  wire logic [15:0] duty_setting_in,
  input  wire logic [3:0]  channel_in,
  input  wire logic [1:0]  time_base_in,
  output var  logic        pulse_out,
  output var  logic        output_active_status_out,
  output var  logic        job_done_out,
  output var  logic        job_error_out,
  output var  logic [15:0] job_status_out,
  output var  logic [31:0] readback_value_out
);
  localparam logic [9:0] FINE_CYC   = 10'(`TB_FINE_NS / `CLK_NS);
  localparam logic [9:0] COARSE_CYC = 10'(`TB_COARSE_NS / `CLK_NS);

  logic        req_rise;
  logic        gate_rise;
  logic        tick;
  job_state_e  job_st_r;
  logic [7:0]  code_r;
  logic [31:0] oper_r;
  logic [3:0]  chan_r;
  logic [1:0]  tb_r;
  logic        start_req_r;
  logic [15:0] err_nxt;
  logic        eval_ok;
  logic [15:0] period1_r;
  logic [15:0] period2_r;
  logic [15:0] minp_r;
  logic [15:0] ondly_r;
  logic [15:0] cnt1_r;
  logic [15:0] cnt2_r;
  logic        job1_def_r;
  logic        job2_def_r;
  logic [1:0]  tb_act_r;
  logic        run_r;
  logic        train_r;
  logic        in_job2_r;
  logic        job2_q_r;
  logic [15:0] pos_r;
  logic [15:0] act_per_r;
  logic [15:0] act_high_r;
  logic [15:0] remain_r;
  logic        go;
  logic        attach_go;
  logic        per_end;
  logic        last_pulse;
  logic [15:0] per_nxt;
  logic [15:0] duty_c;
  logic [31:0] prod;
  logic [15:0] high_nxt;

  // strobe and gate edges versus their previous-cycle values; the host
  // must drop the strobe between jobs or no new edge is seen
  edge_rise #(.W(2)) u_edge (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .level_in   ({job_req_in, software_gate_in}),
    .rise_out   ({req_rise, gate_rise})
  );

  tick_divider #(.W(10)) u_tick (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .run_in     (run_r),
    .div_in     ((tb_act_r == `TB_COARSE) ? COARSE_CYC : FINE_CYC),
    .tick_out   (tick)
  );

  // job capture: a strobe edge is taken only when idle, which the host
  // guarantees by waiting for done before the next job
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      job_st_r    <= JOB_IDLE;
      code_r      <= '0;
      oper_r      <= '0;
      chan_r      <= '0;
      tb_r        <= '0;
      start_req_r <= 1'b0;
    end else begin
      unique case (job_st_r)
        JOB_IDLE: begin
          if (req_rise) begin
            job_st_r    <= JOB_BUSY;
            code_r      <= command_code_in;
            oper_r      <= command_operand_in;
            chan_r      <= channel_in;
            tb_r        <= time_base_in;
            start_req_r <= gate_rise && command_code_in != `JOB_ATTACH;
          end
        end
        JOB_BUSY: begin
          job_st_r    <= JOB_IDLE;
          start_req_r <= 1'b0;
        end
      endcase
    end
  end

  // job evaluation: channel, then time base, then the job itself
  always_comb begin
    err_nxt = `ST_OK;
    if (chan_r > `CHAN_LAST) begin
      err_nxt = `ST_CHAN_BAD;
    end else if (32'(chan_r) >= 32'(NUM_CHANNELS)) begin
      err_nxt = `ST_PARAM_ERR;
    end else if (tb_r != `TB_FINE && tb_r != `TB_COARSE) begin
      err_nxt = `ST_TB_BAD;
    end else if (!start_req_r) begin
      case (code_r)
        `JOB_PERIOD, `JOB_PERIOD2: begin
          if (oper_r < `PER_MIN) err_nxt = `ST_PER_SMALL;
          else if (oper_r > `PER_MAX) err_nxt = `ST_PER_BIG;
        end
        `JOB_ONDELAY: begin
          if (oper_r < `DLY_MIN) err_nxt = `ST_DLY_SMALL;
          else if (oper_r > `DLY_MAX) err_nxt = `ST_DLY_BIG;
        end
        `JOB_MINPULSE: begin
          if (oper_r < `MINP_MIN) err_nxt = `ST_MINP_SMALL;
          else if (oper_r > `MINP_MAX) err_nxt = `ST_MINP_BIG;
        end
        `JOB_COUNT1, `JOB_COUNT2: begin
          if (oper_r < `CNT_MIN) err_nxt = `ST_CNT_SMALL;
          else if (oper_r > `CNT_MAX) err_nxt = `ST_CNT_BIG;
        end
        `JOB_ATTACH: begin
          // first train running, none queued, second one defined
          if (!(run_r && train_r && !in_job2_r && !job2_q_r && job2_def_r)) begin
            err_nxt = `ST_NO_ATTACH;
          end
        end
        `JOB_RD_PERIOD, `JOB_RD_ONDLY, `JOB_RD_MINP, `JOB_RD_REMAIN: begin
          err_nxt = `ST_OK;
        end
        default: err_nxt = `ST_BAD_JOB;
      endcase
    end
  end

  assign eval_ok   = job_st_r == JOB_BUSY && err_nxt == `ST_OK;
  assign go        = eval_ok && start_req_r && software_gate_in;
  assign attach_go = eval_ok && !start_req_r && code_r == `JOB_ATTACH && software_gate_in;

  // result flags: cleared by each new strobe edge, set after evaluation
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      job_done_out   <= 1'b1;
      job_error_out  <= 1'b0;
      job_status_out <= `ST_OK;
    end else if (job_st_r == JOB_IDLE && req_rise) begin
      job_done_out   <= 1'b0;
      job_error_out  <= 1'b0;
      job_status_out <= `ST_OK;
    end else if (job_st_r == JOB_BUSY) begin
      job_done_out   <= 1'b1;
      job_error_out  <= err_nxt != `ST_OK;
      job_status_out <= err_nxt;
    end
  end

  // parameter shadows; running periods never read these mid-period
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period1_r <= 16'(`PER_MIN);
      period2_r <= 16'(`PER_MIN);
      minp_r    <= 16'(`MINP_MIN);
      ondly_r   <= 16'(`DLY_MIN);
      cnt1_r    <= '0;
      cnt2_r    <= '0;
    end else if (eval_ok && !start_req_r) begin
      unique case (code_r)
        `JOB_PERIOD:   period1_r <= oper_r[15:0];
        `JOB_PERIOD2:  period2_r <= oper_r[15:0];
        `JOB_MINPULSE: minp_r    <= oper_r[15:0];
        `JOB_ONDELAY:  ondly_r   <= oper_r[15:0];
        `JOB_COUNT1:   cnt1_r    <= oper_r[15:0];
        `JOB_COUNT2:   cnt2_r    <= oper_r[15:0];
        default: ;
      endcase
    end
  end

  // readback of stored values for read jobs
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      readback_value_out <= '0;
    end else if (eval_ok && !start_req_r) begin
      unique case (code_r)
        `JOB_RD_PERIOD: readback_value_out <= {16'h0000, period1_r};
        `JOB_RD_ONDLY:  readback_value_out <= {16'h0000, ondly_r};
        `JOB_RD_MINP:   readback_value_out <= {16'h0000, minp_r};
        `JOB_RD_REMAIN: readback_value_out <= {16'h0000, remain_r};
        default: ;
      endcase
    end
  end

  // job definitions are consumed by a start, so each job runs once
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      job1_def_r <= 1'b0;
      job2_def_r <= 1'b0;
    end else if (go || attach_go) begin
      job1_def_r <= 1'b0;
      job2_def_r <= 1'b0;
    end else if (eval_ok && code_r == `JOB_COUNT1) begin
      job1_def_r <= 1'b1;
    end else if (eval_ok && code_r == `JOB_COUNT2) begin
      job2_def_r <= 1'b1;
    end
  end

  // next period's figures: duty sampled live, limited to full scale
  assign per_end    = run_r && tick && pos_r == act_per_r - 16'h0001;
  assign last_pulse = train_r && remain_r == 16'h0001;
  assign duty_c     = (duty_setting_in > `DUTY_FULL) ? `DUTY_FULL : duty_setting_in;
  assign per_nxt    = (go ? !job1_def_r : !train_r) ? period1_r
                    : ((go ? 1'b0 : in_job2_r) || (per_end && last_pulse)) ? period2_r
                    : period1_r;
  assign prod       = 32'(per_nxt) * 32'(duty_c);
  // pulses shorter than the minimum are suppressed rather than emitted
  assign high_nxt   = (16'(prod >> `DUTY_SHIFT) < minp_r) ? 16'h0000 : 16'(prod >> `DUTY_SHIFT);

  // run control: start, train chaining and immediate stop
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_r     <= 1'b0;
      train_r   <= 1'b0;
      in_job2_r <= 1'b0;
      job2_q_r  <= 1'b0;
      remain_r  <= '0;
      tb_act_r  <= `TB_FINE;
    end else if (!software_gate_in) begin
      run_r     <= 1'b0;
      train_r   <= 1'b0;
      in_job2_r <= 1'b0;
      job2_q_r  <= 1'b0;
      remain_r  <= '0;
    end else if (go) begin
      run_r     <= 1'b1;
      train_r   <= job1_def_r;
      in_job2_r <= 1'b0;
      job2_q_r  <= job1_def_r && job2_def_r;
      remain_r  <= job1_def_r ? cnt1_r : 16'h0000;
      tb_act_r  <= tb_r;
    end else begin
      if (attach_go) begin
        job2_q_r <= 1'b1;
      end
      if (per_end && train_r) begin
        if (last_pulse && (job2_q_r || attach_go)) begin
          in_job2_r <= 1'b1;
          job2_q_r  <= 1'b0;
          remain_r  <= cnt2_r;
        end else if (last_pulse) begin
          run_r    <= 1'b0;
          train_r  <= 1'b0;
          remain_r <= '0;
        end else begin
          remain_r <= remain_r - 16'h0001;
        end
      end
    end
  end

  // period engine: new figures latched only at a period boundary
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_r      <= '0;
      act_per_r  <= 16'(`PER_MIN);
      act_high_r <= '0;
    end else if (!software_gate_in || (per_end && last_pulse && !job2_q_r && !attach_go)) begin
      pos_r <= '0;
    end else if (go || per_end) begin
      pos_r      <= '0;
      act_per_r  <= per_nxt;
      act_high_r <= high_nxt;
    end else if (run_r && tick) begin
      pos_r <= pos_r + 16'h0001;
    end
  end

  // registered outputs; the channel has no event or interrupt line
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulse_out                <= 1'b0;
      output_active_status_out <= 1'b0;
    end else if (!software_gate_in) begin
      pulse_out                <= 1'b0;
      output_active_status_out <= 1'b0;
    end else if (go) begin
      pulse_out                <= high_nxt != 16'h0000;
      output_active_status_out <= 1'b1;
    end else if (per_end && last_pulse && !job2_q_r && !attach_go) begin
      pulse_out                <= 1'b0;
      output_active_status_out <= 1'b0;
    end else if (per_end) begin
      pulse_out <= high_nxt != 16'h0000;
    end else if (run_r && tick) begin
      pulse_out <= (pos_r + 16'h0001) < act_high_r;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_new_req;
    job_st_r == JOB_IDLE && req_rise;
  endsequence
  sequence s_minp_ok;
    s_new_req ##0 command_code_in == `JOB_MINPULSE && command_operand_in == 32'h0000_0010
      && channel_in == 4'h0 && time_base_in == `TB_FINE && !gate_rise;
  endsequence

  a_done_busy_window: assert property (s_new_req |=> !job_done_out ##1 job_done_out)
    else $error("done flag not low for exactly one busy cycle");
  a_req_clears_err: assert property (s_new_req |=> !job_error_out && job_status_out == `ST_OK)
    else $error("new request did not clear error and result");
  a_err_has_code: assert property (job_error_out |-> job_status_out != `ST_OK)
    else $error("error flag without a cause code");
  a_minp_load: assert property (s_minp_ok |=> ##1 minp_r == 16'h0010 && !job_error_out)
    else $error("minimum pulse duration not loaded");
  a_gate_stop: assert property (!software_gate_in |=> !pulse_out && !output_active_status_out)
    else $error("output not stopped by gate low");
  a_start_active: assert property (go |=> output_active_status_out && run_r)
    else $error("start did not raise active status");
  a_period_held: assert property (run_r && !per_end && !go && software_gate_in |=> $stable(act_per_r))
    else $error("period changed inside a running period");
  a_two_jobs_max: assert property (in_job2_r |-> !job2_q_r)
    else $error("third train job queued");
  a_attach_refused: assert property (job_st_r == JOB_BUSY && code_r == `JOB_ATTACH && !start_req_r
      && err_nxt == `ST_OK |-> job2_def_r && train_r)
    else $error("attach accepted without a defined second job");
  a_unknown_job: assert property (job_st_r == JOB_BUSY && !start_req_r && chan_r <= `CHAN_LAST
      && 32'(chan_r) < 32'(NUM_CHANNELS) && tb_r == `TB_FINE
      && code_r == 8'h7F |=> job_status_out == `ST_BAD_JOB)
    else $error("unknown job not reported");
endmodule // pulse_output_function_block
`default_nettype wire

// [test/host_job_driver.sv]
/*
  Host model that issues jobs to the pulse output controller.
  Assumes one rising-edge clock and a done flag that is high while idle.
*/
`timescale 1ns/100ps
`default_nettype none
module host_job_driver (
  input  wire logic        clk_sys_in,
  input  wire logic        job_done_in,
  output var  logic        job_req_out,
  output var  logic        software_gate_out,
  output var  logic [7:0]  command_code_out,
  output var  logic [31:0] command_operand_out,
  output var  logic [3:0]  channel_out,
  output var  logic [1:0]  time_base_out
);
  logic busy_seen;

  // request lines idle at time zero
  initial begin
    job_req_out = 1'b0;
    software_gate_out = 1'b0;
    command_code_out = 8'h00;
    command_operand_out = 32'h0000_0000;
    channel_out = 4'h0;
    time_base_out = 2'h0;
    busy_seen = 1'b1;
  end

  // one job: strobe up with stable fields; done drops on the edge that takes it, returns the next
  task automatic job(input logic [7:0] c, input logic [31:0] v, input logic [3:0] ch, input logic [1:0] tb,
                     input logic g);
    int n;
    n = 0;
    // bounded wait, so a stuck done flag cannot hang the host
    while (job_done_in !== 1'b1 && n < 64) begin
      @(posedge clk_sys_in);
      n++;
    end
    @(posedge clk_sys_in);
    job_req_out <= 1'b1;
    command_code_out <= c;
    command_operand_out <= v;
    channel_out <= ch;
    time_base_out <= tb;
    software_gate_out <= g;
    @(posedge clk_sys_in);
    #1 busy_seen = job_done_in;
    @(posedge clk_sys_in);
    job_req_out <= 1'b0; // only the strobe drops, the fields stay put
  endtask

  // stop request: the gate alone goes low
  task automatic gate_low();
    @(posedge clk_sys_in);
    software_gate_out <= 1'b0;
  endtask
endmodule // host_job_driver
`default_nettype wire

// [test/pulse_output_function_block_bench.sv]
/*
  Self-checking bench of the pulse output controller with a host model.
  Assumes 100 MHz clock, 1 us time base unit = 100 clocks, duty 4000h = 100%.
*/
`timescale 1ns/100ps
`default_nettype none
module pulse_output_function_block_bench;
  localparam int NCH = 4;
  logic        clk_sys_in;
  logic        rstn_in;
  logic        job_req, gate, pulse, active, done, err;
  logic [7:0]  code;
  logic [31:0] operand, readback;
  logic [15:0] duty, status;
  logic [3:0]  chan;
  logic [1:0]  tbase;
  logic        p_prev;
  int          errors, checks_done, rises, act, n, c;
  longint      v, stored[16];
  logic [31:0] rng;

  host_job_driver host (.clk_sys_in(clk_sys_in), .job_done_in(done), .job_req_out(job_req),
    .software_gate_out(gate), .command_code_out(code), .command_operand_out(operand),
    .channel_out(chan), .time_base_out(tbase));

  pulse_output_function_block #(.NUM_CHANNELS(NCH)) uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .job_req_in(job_req), .software_gate_in(gate), .command_code_in(code),
    .command_operand_in(operand), .duty_setting_in(duty), .channel_in(chan), .time_base_in(tbase),
    .pulse_out(pulse), .output_active_status_out(active), .job_done_out(done),
    .job_error_out(err), .job_status_out(status), .readback_value_out(readback));

  always #5 clk_sys_in = ~clk_sys_in;

  // pulse starts and active cycles, counted beside the main sequence
  always @(posedge clk_sys_in) begin
    p_prev <= pulse;
    if (pulse === 1'b1 && p_prev === 1'b0) rises++;
    if (active === 1'b1) act++;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // result code of a parameter or read job, from the ranges and checks
  function automatic int exp_stat(int cc, longint vv, int ch, int tb);
    if (ch > 3) return 16'h8009;
    if (ch >= NCH) return 16'h8001;
    if (tb > 1) return 16'h0451;
    case (cc)
      8'h01, 8'h0A: return vv < 2 ? 16'h0411 : vv > 60000 ? 16'h0412 : 0;
      8'h02: return vv < 1 ? 16'h0421 : vv > 60000 ? 16'h0422 : 0;
      8'h04: return vv < 1 ? 16'h0431 : vv > 60000 ? 16'h0432 : 0;
      8'h08, 8'h09: return vv < 1 ? 16'h0441 : vv > 65535 ? 16'h0442 : 0;
      8'h81, 8'h82, 8'h84, 8'h88: return 0;
      default: return 16'h04FF;
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      errors++;
    end
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one job through the host, then the answer against the model
  task automatic run(input int cc, input longint vv, input int g, input int ch, input int tb, input int e);
    host.job(cc[7:0], vv[31:0], ch[3:0], tb[1:0], g[0]);
    #1;
    check("done_busy", {31'h0, host.busy_seen}, 0);
    check("done_end", {31'h0, done}, 1);
    check("error", {31'h0, err}, {31'h0, e != 0});
    check("status", {16'h0, status}, e);
    if (e == 0 && cc < 16) stored[cc] = vv;
  endtask

  // cycles the pulse keeps one level, capped at 300
  task automatic span(input logic lvl, output int k);
    k = 0;
    while (pulse === lvl && k < 300) begin
      @(posedge clk_sys_in);
      #1;
      k++;
    end
  endtask

  // wait until the output goes idle, bounded
  task automatic drain();
    n = 0;
    while (active === 1'b1 && n < 3000) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask

  // span of roughly twenty times the planned run
  initial begin
    #(50000 * 10);
    errors++;
    results();
  end

  initial begin
    clk_sys_in = 1'b0;
    rstn_in = 1'b0;
    duty = 16'h2000;
    rng = 32'd45;
    errors = 0;
    checks_done = 0;
    rises = 0;
    act = 0;
    p_prev = 1'b0;
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    #1;
    check("reset_done", {31'h0, done}, 1);
    check("reset_active", {31'h0, active}, 0);
    check("reset_status", {16'h0, status}, 0);
    // range, code, channel and time base refusals, spread over channels and bases
    for (int i = 0; i < 14; i++) begin
      automatic int tc[14] = '{8'h04, 8'h04, 8'h01, 8'h01, 8'h0A, 8'h02, 8'h02, 8'h08, 8'h08, 8'h09, 8'h7F,
                               8'h04, 8'h04, 8'h04};
      automatic longint tv[14] = '{0, 60001, 1, 60001, 70000, 0, 60001, 0, 65536, 65536, 5, 5, 5, 5};
      int ch;
      int tb;
      ch = i == 11 ? 4 : i % 4;
      tb = i == 12 ? 2 : i == 13 ? 3 : i % 2;
      run(tc[i], tv[i], 0, ch, tb, exp_stat(tc[i], tv[i], ch, tb));
    end
    // random valid writes, each read back through its read job
    for (int i = 0; i < 6; i++) begin
      c = i % 3 == 0 ? 8'h01 : i % 3 == 1 ? 8'h02 : 8'h04;
      v = 2 + xs() % 59999;
      run(c, v, 0, xs() % 4, i % 2, 0);
      run(c + 8'h80, 0, 0, 0, 0, 0);
      check("readback", readback, stored[c][31:0]);
    end
    run(8'h04, 16, 0, 0, 0, 0);
    // pwm: period 2 units, half duty gives one unit high
    run(8'h01, 2, 0, 0, 0, 0);
    run(8'h04, 1, 0, 0, 0, 0);
    run(8'h00, 0, 1, 0, 0, 0);
    check("pwm_active", {31'h0, active}, 1);
    span(1'b1, n);
    span(1'b0, n);
    check("pwm_low", n, 100);
    @(posedge clk_sys_in) duty <= 16'h4000;
    span(1'b1, n);
    check("pwm_old_duty", n, 100 - 1); // one cycle spent on the duty update
    span(1'b0, n);
    check("pwm_old_low", n, 100);
    span(1'b1, n);
    check("pwm_new_duty", n, 300); // full duty keeps the pulse up
    check("pwm_still_on", {31'h0, active}, 1);
    host.gate_low();
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    #1;
    check("stop_pulse", {31'h0, pulse}, 0);
    check("stop_active", {31'h0, active}, 0);
    // train: 2 periods of 2 units, then 1 period of 3 units
    @(posedge clk_sys_in) duty <= 16'h2000;
    run(8'h08, 2, 0, 0, 0, 0);
    run(8'h01, 2, 0, 0, 0, 0);
    run(8'h09, 1, 0, 0, 0, 0);
    run(8'h0A, 3, 0, 0, 0, 0);
    rises = 0;
    act = 0;
    run(8'h00, 0, 1, 0, 0, 0);
    drain();
    check("train_pulses", rises, 3);
    check("train_length", {31'h0, act >= 698 && act <= 702}, 1);
    // attach with nothing running is refused
    run(8'h0C, 0, 1, 0, 0, 16'h0461);
    host.gate_low();
    run(8'h08, 3, 0, 0, 0, 0);
    run(8'h01, 2, 0, 0, 0, 0);
    rises = 0;
    act = 0;
    run(8'h00, 0, 1, 0, 0, 0);
    run(8'h09, 1, 1, 0, 0, 0);
    run(8'h0A, 2, 1, 0, 0, 0);
    run(8'h0C, 0, 1, 0, 0, 0);
    run(8'h0C, 0, 1, 0, 0, 16'h0461); // a third job cannot chain
    drain();
    check("attach_pulses", rises, 4);
    check("attach_length", {31'h0, act >= 798 && act <= 802}, 1);
    results();
  end
endmodule // pulse_output_function_block_bench
`default_nettype wire
